/* File: shared/cas_regs.svh */
// register offsets, field positions and reset values of the audio serial port
// assumes word-addressed avalon slave, registers in low byte of each word
`ifndef CAS_REGS_SVH
`define CAS_REGS_SVH
`define CAS_OFS_FORMAT 6'h1b
`define CAS_OFS_OFFSET 6'h1c
`define CAS_OFS_CTRL3 6'h1d
`define CAS_OFS_BDIV 6'h1e
`define CAS_OFS_MODE 6'h20
`define CAS_OFS_STATUS 6'h21
`define CAS_FMT_TRI_BIT 0
`define CAS_FMT_WCLK_MST_BIT 2
`define CAS_FMT_BCLK_MST_BIT 3
`define CAS_FMT_WLEN_LO 4
`define CAS_FMT_MODE_LO 6
`define CAS_CT3_INV_BIT 3
`define CAS_MODE_ADC_PWR_BIT 0
`define CAS_MODE_DAC_PWR_BIT 1
`define CAS_MODE_CONT_BIT 2
`define CAS_MODE_PULSE_BIT 3
`define CAS_RST_FORMAT 8'h00
`define CAS_RST_OFFSET 8'h00
`define CAS_RST_CTRL3 8'h00
`define CAS_RST_BDIV 8'h01
`define CAS_RST_MODE 8'h00
`define CAS_FRAME_BITS 8'h40
`endif

/* File: shared/cas_pkg.sv */
// types of the audio serial port
// assumes cas_regs.svh supplies the numbers
package cas_pkg;
    typedef enum logic [1:0] {CAS_I2S = 2'h0, CAS_DSP = 2'h1, CAS_RJF = 2'h2, CAS_LJF = 2'h3} cas_fmt_t;
    typedef enum logic [2:0] {CAS_ST_IDLE = 3'h1, CAS_ST_RUN = 3'h2, CAS_ST_ACK = 3'h4} cas_bus_st_t;
    typedef struct packed {
        logic sclk;
        logic wclk;
        logic dout;
        logic sclk_oe;
        logic wclk_oe;
        logic dout_oe;
    } cas_pins_t;
    typedef struct packed {
        cas_bus_st_t bus;
        logic [7:0] fmt;
        logic [7:0] ofs;
        logic [7:0] ct3;
        logic [7:0] bdiv;
        logic [7:0] mode;
        logic [7:0] divc;
        logic [7:0] bitc;
        logic sck_int;
        logic [31:0] tx_sh;
        logic [31:0] rx_sh;
        logic [31:0] rx_word;
        logic rx_valid;
        logic tx_ready;
        logic [31:0] rdata;
        logic [1:0] s_sclk;
        logic [1:0] s_wclk;
        logic [1:0] s_din;
        logic prev_sclk;
        logic prev_wclk;
        cas_pins_t pins;
    } cas_state_t;
endpackage

/* File: logic/cas_serial_port.sv */
// audio serial port: framing, clock master/slave, register slave over avalon-mm
// assumes one 125 MHz clock; slave-mode pins are asynchronous and synchronised here
// Notes on behaviour
// - supports i2s, dsp, left and right justified; tdm/pcm via dsp plus offset
// - every word shifted msb first
// - word length 16, 20, 24 or 32 from format bits 5:4
// - word clock and bit clock master or slave independently
// - word clock edge starts frame; pulse or square wave selectable
// - word clock as master runs once every 64 bit clocks, whatever the adc and dac rates
// - bit clock as master divided by twice the bit clock divider register
// - first data bit delayed by data offset register in bit clocks
// - polarity bit 3 of control three inverts the data bit clock edge
// - format bit 0 tri-states data output on bits without valid data
// - powered down as master puts data output high impedance, and both clocks too unless continuous is set
// - generated clocks run only while adc or dac is powered or continuous is set
// - continuous setting keeps generated clocks running while powered down
`timescale 1ns/1ps
`include "cas_regs.svh"
module cas_serial_port (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_sclk,
    input wire logic i_wclk,
    input wire logic i_din,
    output logic o_sclk,
    output logic o_sclk_oe,
    output logic o_wclk,
    output logic o_wclk_oe,
    output logic o_dout,
    output logic o_dout_oe,
    input wire logic [31:0] i_tx_word,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic [31:0] o_rx_word,
    output logic o_rx_valid
);
    cas_pkg::cas_state_t q, d;

    // register bus timing: a request is taken in idle, the register is read
    // one cycle later and waitrequest drops for one cycle after that
    // a write lands on that same answering edge, so software never sees a
    // register change before its own write has been acknowledged
    // serial side: everything runs on the system clock; as master the bit
    // clock is a divided level, as slave both clocks pass two flip-flops
    // limitation: the divider must give at least three system cycles per half
    // bit clock, or returning data misses its sampling edge
    // limitation: a slave frame longer than 256 bit clocks stops counting at
    // the top and sends nothing more until the next word clock edge
    // trade-off: one fixed 64-bit master frame keeps the counter small; the
    // divider sets the rate, software sets the word and offset inside it

    function automatic logic [5:0] cas_wlen(input logic [1:0] code);
        case (code)
            2'h0: cas_wlen = 6'h10;
            2'h1: cas_wlen = 6'h14;
            2'h2: cas_wlen = 6'h18;
            default: cas_wlen = 6'h20;
        endcase
    endfunction

    // edge of a sampled level against its copy one cycle older
    // used for both clocks so master and slave see edges the same way
    function automatic logic cas_edge(
        input logic now_lvl,
        input logic old_lvl,
        input logic rising
    );
        if (rising)
            cas_edge = now_lvl & ~old_lvl;
        else
            cas_edge = ~now_lvl & old_lvl;
    endfunction

    // bit position of the first data bit in a frame
    // right justified ends the word on the last bit of the first half frame
    function automatic logic [7:0] cas_start_pos(
        input cas_pkg::cas_fmt_t mode_sel,
        input logic [7:0] ofs,
        input logic [5:0] len
    );
        case (mode_sel)
            cas_pkg::CAS_I2S:
                cas_start_pos = ofs + 8'h1;
            cas_pkg::CAS_RJF:
                cas_start_pos = ofs + (`CAS_FRAME_BITS >> 1) - {2'h0, len};
            default:
                cas_start_pos = ofs;
        endcase
    endfunction

    // true while a bit position lies inside the data word
    // shared by send and receive so both agree on the window
    function automatic logic cas_in_word(
        input logic [7:0] pos,
        input logic [7:0] first,
        input logic [5:0] len
    );
        logic [7:0] rel_pos;
        rel_pos = pos - first;
        cas_in_word = (pos >= first) && (rel_pos < {2'h0, len});
    endfunction

    // register read decode; unmapped offsets read zero
    function automatic logic [31:0] cas_rd_value(
        input logic [5:0] addr,
        input cas_pkg::cas_state_t s
    );
        case (addr)
            `CAS_OFS_FORMAT:
                cas_rd_value = {24'h0, s.fmt};
            `CAS_OFS_OFFSET:
                cas_rd_value = {24'h0, s.ofs};
            `CAS_OFS_CTRL3:
                cas_rd_value = {24'h0, s.ct3};
            `CAS_OFS_BDIV:
                cas_rd_value = {24'h0, s.bdiv};
            `CAS_OFS_MODE:
                cas_rd_value = {24'h0, s.mode};
            `CAS_OFS_STATUS:
                cas_rd_value = {24'h0, s.bitc};
            default:
                cas_rd_value = 32'h0;
        endcase
    endfunction

    // mask that keeps the low len bits; a full 32-bit word keeps all
    function automatic logic [31:0] cas_wmask(input logic [5:0] len);
        if (len == 6'h20)
            cas_wmask = 32'hffffffff;
        else
            cas_wmask = (32'h1 << len) - 32'h1;
    endfunction

    logic bclk_mst, wclk_mst, powered, clk_run, inv;
    logic sck, wck, rise, fall, shift_edge, samp_edge, frame_start, wck_edge;
    logic [5:0] wlen;
    logic [7:0] start, rel;
    cas_pkg::cas_fmt_t fmt;
    logic [7:0] half_frame;
    logic in_word, tx_in;

    always_comb
    begin
        d = q;
        bclk_mst = q.fmt[`CAS_FMT_BCLK_MST_BIT];
        wclk_mst = q.fmt[`CAS_FMT_WCLK_MST_BIT];
        fmt = cas_pkg::cas_fmt_t'(q.fmt[`CAS_FMT_MODE_LO +: 2]);
        wlen = cas_wlen(q.fmt[`CAS_FMT_WLEN_LO +: 2]);
        inv = q.ct3[`CAS_CT3_INV_BIT];
        powered = q.mode[`CAS_MODE_ADC_PWR_BIT] | q.mode[`CAS_MODE_DAC_PWR_BIT];
        clk_run = powered | q.mode[`CAS_MODE_CONT_BIT];
        half_frame = `CAS_FRAME_BITS >> 1;
        // bus slave: two wait cycles, answer on the second edge
        d.bus = q.bus;
        case (q.bus)
            cas_pkg::CAS_ST_IDLE:
            begin
                if (i_avs_read || i_avs_write)
                    d.bus = cas_pkg::CAS_ST_RUN;
            end
            cas_pkg::CAS_ST_RUN:
            begin
                d.bus = cas_pkg::CAS_ST_ACK;
                d.rdata = cas_rd_value(i_avs_address, q);
            end
            cas_pkg::CAS_ST_ACK:
            begin
                // write lands on the edge at which the master sees waitrequest low
                d.bus = cas_pkg::CAS_ST_IDLE;
                if (i_avs_write && i_avs_byteenable[0])
                begin
                    case (i_avs_address)
                        `CAS_OFS_FORMAT: d.fmt = i_avs_writedata[7:0];
                        `CAS_OFS_OFFSET: d.ofs = i_avs_writedata[7:0];
                        `CAS_OFS_CTRL3: d.ct3 = i_avs_writedata[7:0];
                        `CAS_OFS_BDIV: d.bdiv = i_avs_writedata[7:0];
                        `CAS_OFS_MODE: d.mode = i_avs_writedata[7:0];
                        default: d.mode = q.mode;
                    endcase
                end
            end
            default: d.bus = cas_pkg::CAS_ST_IDLE;
        endcase

        // synchronisers; stage 0 is read only by stage 1
        d.s_sclk = {q.s_sclk[0], i_sclk};
        d.s_wclk = {q.s_wclk[0], i_wclk};
        d.s_din = {q.s_din[0], i_din};

        // master bit clock from divider; divider 0 treated as 256
        // count reloads on each toggle, so a new divider value takes
        // effect at the next half period without a glitch
        d.sck_int = q.sck_int;
        d.divc = q.divc;
        if (bclk_mst && clk_run)
        begin
            if (q.divc == 8'h0)
            begin
                d.divc = q.bdiv - 8'h1;
                d.sck_int = ~q.sck_int;
            end
            else
                d.divc = q.divc - 8'h1;
        end
        else
        begin
            d.divc = 8'h0;
            d.sck_int = 1'b0;
        end
        sck = bclk_mst ? q.sck_int : q.s_sclk[1];
        d.prev_sclk = sck;
        rise = cas_edge(sck, q.prev_sclk, 1'b1);
        fall = cas_edge(sck, q.prev_sclk, 1'b0);
        shift_edge = inv ? rise : fall;
        samp_edge = inv ? fall : rise;

        // frame position: master counts, slave follows word clock edges
        wck = wclk_mst ? q.pins.wclk : q.s_wclk[1];
        d.prev_wclk = wck;
        // dsp mode frames on rising edge; others on falling (left channel low)
        if (fmt == cas_pkg::CAS_DSP)
            wck_edge = cas_edge(wck, q.prev_wclk, 1'b1);
        else
            wck_edge = cas_edge(wck, q.prev_wclk, 1'b0);
        d.bitc = q.bitc;
        frame_start = 1'b0;
        if (shift_edge)
        begin
            if (wclk_mst)
            begin
                // one frame of fixed bit clocks per word clock period
                d.bitc = (q.bitc == `CAS_FRAME_BITS - 8'h1) ? 8'h0 : q.bitc + 8'h1;
                frame_start = (q.bitc == `CAS_FRAME_BITS - 8'h1);
            end
            else if (wck_edge)
            begin
                d.bitc = 8'h0;
                frame_start = 1'b1;
            end
            else if (q.bitc != 8'hff)
                // a missing word clock edge must not wrap into a false frame
                d.bitc = q.bitc + 8'h1;
        end

        // word start position per format
        start = cas_start_pos(fmt, q.ofs, wlen);
        rel = q.bitc - start;
        in_word = cas_in_word(q.bitc, start, wlen);

        // master word clock output: pulse or square wave
        // pulse marks only the first bit clock of the frame
        d.pins.wclk = q.pins.wclk;
        if (wclk_mst && clk_run && shift_edge)
        begin
            if (q.mode[`CAS_MODE_PULSE_BIT] || fmt == cas_pkg::CAS_DSP)
                d.pins.wclk = (d.bitc == 8'h0);
            else
                d.pins.wclk = (d.bitc >= half_frame);
        end
        else if (!(wclk_mst && clk_run))
            d.pins.wclk = 1'b0;

        // transmit and receive shifts, msb first
        d.tx_ready = 1'b0;
        d.rx_valid = 1'b0;
        tx_in = 1'b0;
        if (shift_edge)
        begin
            // the bit put out now is sampled at the position the counter moves to
            tx_in = cas_in_word(d.bitc, start, wlen);
            if (frame_start)
            begin
                d.tx_sh = i_tx_valid ? (i_tx_word << (6'h20 - wlen)) : 32'h0;
                d.tx_ready = 1'b1;
            end
            else if (tx_in && d.bitc != start)
                d.tx_sh = {q.tx_sh[30:0], 1'b0};
            d.pins.dout = d.tx_sh[31];
            d.pins.dout_oe = powered & (tx_in | ~q.fmt[`CAS_FMT_TRI_BIT]);
        end
        // receive samples on the opposite edge, half a bit clock after launch,
        // which leaves room for the two synchroniser stages
        if (samp_edge && in_word)
        begin
            d.rx_sh = {q.rx_sh[30:0], q.s_din[1]};
            if (rel == {2'h0, wlen} - 8'h1)
            begin
                d.rx_word = {q.rx_sh[30:0], q.s_din[1]} & cas_wmask(wlen);
                d.rx_valid = 1'b1;
            end
        end
        // let the data pin go while powered down so another codec can own the bus
        if (!powered)
            d.pins.dout_oe = 1'b0;
        d.pins.sclk = q.sck_int;
        d.pins.sclk_oe = bclk_mst & clk_run;
        d.pins.wclk_oe = wclk_mst & clk_run;
    end

    // reset clears the whole state, then the registers get their defaults
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            q <= '0;
            q.bus <= cas_pkg::CAS_ST_IDLE;
            q.fmt <= `CAS_RST_FORMAT;
            q.ofs <= `CAS_RST_OFFSET;
            q.ct3 <= `CAS_RST_CTRL3;
            q.bdiv <= `CAS_RST_BDIV;
            q.mode <= `CAS_RST_MODE;
        end
        else
            q <= d;
    end

    // outputs are plain copies of flip-flops, except waitrequest, decoded from the bus state
    always_comb
    begin
        o_avs_readdata = q.rdata;
        o_avs_waitrequest = (q.bus != cas_pkg::CAS_ST_ACK);
        o_sclk = q.pins.sclk;
        o_sclk_oe = q.pins.sclk_oe;
        o_wclk = q.pins.wclk;
        o_wclk_oe = q.pins.wclk_oe;
        o_dout = q.pins.dout;
        o_dout_oe = q.pins.dout_oe;
        o_tx_ready = q.tx_ready;
        o_rx_word = q.rx_word;
        o_rx_valid = q.rx_valid;
    end
endmodule

/* File: tb/cas_port_monitor.sv */
// port checker of the audio serial port
// assumes bind onto cas_serial_port; one clock domain
`timescale 1ns/1ps
module cas_port_monitor (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_tx_ready,
    input wire logic o_rx_valid
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    property p_rd; $rose(i_avs_read) |-> o_avs_waitrequest ##1 o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
    a_rd: assert property (p_rd) else $error("read answer not in cycle two");
    property p_wr; $rose(i_avs_write) |-> o_avs_waitrequest [*2] ##1 !o_avs_waitrequest; endproperty
    a_wr: assert property (p_wr) else $error("write answer not in cycle two");
    property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("ack longer than one cycle");
    property p_req; !o_avs_waitrequest |-> i_avs_read || i_avs_write; endproperty
    a_req: assert property (p_req) else $error("ack without request");
    property p_idle; !i_avs_read && !i_avs_write |-> o_avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("waitrequest low while idle");
    property p_hold; !o_avs_waitrequest |=> $stable(o_avs_readdata); endproperty
    a_hold: assert property (p_hold) else $error("read data not held");
    property p_rdy; o_tx_ready |=> (!o_tx_ready) [*8]; endproperty
    a_rdy: assert property (p_rdy) else $error("word taken twice too soon");
    property p_rxv; o_rx_valid |=> (!o_rx_valid) [*8]; endproperty
    a_rxv: assert property (p_rxv) else $error("receive pulse too close");
endmodule

/* File: tb/cas_far_port.sv */
// far-side audio port model: loops serial data straight back
// assumes the device is master of both clocks
`timescale 1ns/1ps
module cas_far_port (
    input wire logic i_mclk,
    input wire logic i_sclk,
    input wire logic i_sclk_oe,
    input wire logic i_wclk,
    input wire logic i_wclk_oe,
    input wire logic i_dout,
    input wire logic i_dout_oe,
    output logic o_sclk,
    output logic o_wclk,
    output logic o_din
);
    logic last_q = 1'b0;
    always_ff @(posedge i_mclk)
        if (i_dout_oe)
            last_q <= i_dout;
    // far clocks stand still low when nobody drives them
    assign o_sclk = i_sclk_oe ? i_sclk : 1'b0;
    assign o_wclk = i_wclk_oe ? i_wclk : 1'b0;
    // released line shows inverse so stale data never matches
    assign o_din = i_dout_oe ? i_dout : ~last_q;
endmodule

/* File: tb/tb_top.sv */
// testbench of the audio serial port with loop-back far side
// assumes 125 MHz clock; device is master of both clocks
`timescale 1ns/1ps
module tb_top;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] txw = 32'h8d3ca5c3;
    logic [31:0] q, rdat, rxw;
    logic sclk, wclk, din, wreq, so, soe, wo, woe, dout, doe, trdy, rxv;
    logic ps = 1'b0;
    logic pd = 1'b0;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n_rise = 0;
    int n_fall = 0;
    int n_hiz = 0;
    always #4 i_mclk = ~i_mclk;
    cas_serial_port DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_sclk(sclk), .i_wclk(wclk), .i_din(din), .o_sclk(so), .o_sclk_oe(soe),
        .o_wclk(wo), .o_wclk_oe(woe), .o_dout(dout), .o_dout_oe(doe), .i_tx_word(txw), .i_tx_valid(1'b1),
        .o_tx_ready(trdy), .o_rx_word(rxw), .o_rx_valid(rxv));
    cas_far_port FAR (.i_mclk(i_mclk), .i_sclk(so), .i_sclk_oe(soe), .i_wclk(wo), .i_wclk_oe(woe),
        .i_dout(dout), .i_dout_oe(doe), .o_sclk(sclk), .o_wclk(wclk), .o_din(din));
    // a data change is filed under the clock level it appears with
    always @(posedge i_mclk)
    begin
        if (dout !== pd)
            if (so) n_rise++; else n_fall++;
        if (soe && !doe) n_hiz++;
        ps <= so;
        pd <= dout;
        cyc++;
        if (cyc == 90000)
        begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge i_mclk); while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic w8(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask
    task automatic rxwait();
        do @(posedge i_mclk); while (rxv !== 1'b1);
    endtask
    // cycles between two rises, and high cycles in between
    task automatic per(input logic ws, output int n, output int h);
        logic p;
        int e;
        p = 1'b1; e = 0; n = 0; h = 0;
        while (e < 2)
        begin
            @(posedge i_mclk);
            if (e == 1) n++;
            if (e == 1 && (ws ? wo : so)) h++;
            if ((ws ? wo : so) && !p) e++;
            p = ws ? wo : so;
        end
    endtask
    task automatic lat(output int n);
        do @(posedge i_mclk); while (wo !== 1'b0);
        do @(posedge i_mclk); while (wo !== 1'b1);
        n = 0;
        while (doe !== 1'b1)
        begin
            @(posedge i_mclk);
            n++;
        end
    endtask
    task automatic t_regs();
        logic [5:0] a[5] = '{6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h20};
        logic [7:0] e[5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
        foreach (a[i])
        begin
            bus(1'b0, a[i], 32'h0);
            chk("reset", q, {24'h0, e[i]});
        end
        w8(6'h05, 8'hff);
        bus(1'b0, 6'h05, 32'h0);
        chk("unmapped", q, 32'h0);
        w8(6'h1c, 8'h5a);
        bus(1'b0, 6'h1c, 32'h0);
        chk("offset", q, 32'h5a);
        w8(6'h1c, 8'h00);
    endtask
    task automatic t_clk();
        int n;
        int h;
        w8(6'h1b, 8'h0c);
        repeat (40) @(posedge i_mclk);
        chk("oe_down", {soe, woe, doe}, 32'h0);
        w8(6'h1e, 8'h04);
        w8(6'h20, 8'h01);
        per(1'b0, n, h);
        chk("bclk", n, 32'h8);
        per(1'b1, n, h);
        chk("frame", n, 32'h200);
        chk("square", h, 32'h100);
        w8(6'h20, 8'h04);
        per(1'b0, n, h);
        chk("cont", n, 32'h8);
        w8(6'h20, 8'h01);
    endtask
    task automatic t_data();
        logic [31:0] m;
        for (int f = 0; f < 4; f++)
            for (int l = 0; l < 4; l++)
            begin
                m = l == 3 ? 32'hffffffff : (32'h1 << (16 + 4 * l)) - 32'h1;
                w8(6'h1b, {f[1:0], l[1:0], 4'hc});
                repeat (3) rxwait();
                chk("loop", rxw, txw & m);
            end
    endtask
    task automatic t_edge();
        int r;
        int z;
        int a;
        w8(6'h1b, 8'hcc);
        repeat (2) rxwait();
        r = n_rise; z = n_hiz;
        repeat (4) rxwait();
        chk("rise", n_rise - r, 32'h0);
        chk("hiz_off", n_hiz - z, 32'h0);
        w8(6'h1d, 8'h08);
        repeat (2) rxwait();
        r = n_fall;
        repeat (4) rxwait();
        chk("fall", n_fall - r, 32'h0);
        chk("inv", rxw, txw & 32'hffff);
        w8(6'h1b, 8'hcd);
        lat(a);
        chk("hiz_on", n_hiz > z, 32'h1);
        w8(6'h1c, 8'h05);
        repeat (2) rxwait();
        lat(r);
        chk("delay", r - a, 32'h28);
    endtask
    initial
    begin
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        @(posedge i_mclk);
        t_regs();
        t_clk();
        t_data();
        t_edge();
        close_out();
    end
endmodule
bind cas_serial_port cas_port_monitor MON (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid));
